// ---- rafc_defines.svh ----
// Purpose: constants for the regeneration avoidance frequency compensator
// Assumes: voltages in 1 V units, frequencies in 0.01 Hz units, gains in percent
// Notes:   shared by the package users and the top module
`ifndef RAFC_DEFINES_SVH
`define RAFC_DEFINES_SVH

// Mode field encodings
`define RAFC_MODE_OFF        2'h0
`define RAFC_MODE_ALWAYS     2'h1
`define RAFC_MODE_CONST      2'h2

// Threshold range in volts DC
`define RAFC_THR_MIN         10'h12C
`define RAFC_THR_MAX         10'h320
`define RAFC_THR_RESET       10'h190

// Compensation limit in 0.01 Hz, 9999 disables the limit
`define RAFC_LIM_MAX         14'h03E8
`define RAFC_LIM_DEFAULT     14'h0258
`define RAFC_LIM_OFF         14'h270F

// Gain range in percent
`define RAFC_GAIN_MAX        8'hC8
`define RAFC_GAIN_UNITY      8'h64

// Control cycle period
`define RAFC_CYCLE_US        100
`define RAFC_CLK_MHZ         25

`endif

// ---- rafc_pkg.sv ----
// Purpose: types for the regeneration avoidance frequency compensator
// Assumes: frequencies in 0.01 Hz units
// Notes:   configuration travels as one packed struct
package rafc_pkg;

    typedef struct packed {
        logic [1:0]  avoidance_mode_select;
        logic [9:0]  avoidance_bus_threshold;
        logic [13:0] compensation_freq_limit;
        logic [7:0]  avoidance_voltage_gain;
        logic [7:0]  avoidance_frequency_gain;
        logic [15:0] max_output_frequency;
    } rafc_cfg_t;

    typedef enum logic [1:0] {
        RAFC_IDLE = 2'b00,
        RAFC_ACT  = 2'b01,
        RAFC_HOLD = 2'b11
    } rafc_state_t;

endpackage : rafc_pkg

// ---- rafc_scale.sv ----
// Purpose: percent scaling of an unsigned value with saturation
// Assumes: gain in percent, 0 to 200
// Notes:   combinational; result saturates to the output width
`timescale 1ns/100ps
module rafc_scale #(
    parameter int W = 16
) (
    input  wire logic [W-1:0] val,   // Value to scale
    input  wire logic [7:0]   gain,  // Gain in percent
    output logic      [W-1:0] res    // Scaled, saturated
);
    logic [W+7:0] prod;
    logic [W+7:0] quot;

    // Multiply then divide by 100; divide kept constant for synthesis
    always_comb begin
        prod = {8'h00, val} * {{W{1'b0}}, gain};
        quot = prod / (W+8)'(100);
        res  = (|quot[W+7:W]) ? {W{1'b1}} : quot[W-1:0];
    end
endmodule : rafc_scale

// ---- rafc_core.sv ----
// Purpose: regeneration avoidance frequency compensation for a motor drive
// Assumes: bus voltage sample and ramp state come from the same clock domain
// Notes:   compensation steps once per control cycle; clearing on disarm is immediate when active, while the hold state clears only on mode off
`timescale 1ns/100ps
`include "rafc_defines.svh"
module rafc_core
    import rafc_pkg::*;
#(
    parameter int VW          = 10,                                     // Bus voltage width
    parameter int FW          = 16,                                     // Frequency width
    parameter int CYCLE_CLKS  = `RAFC_CYCLE_US * `RAFC_CLK_MHZ          // Control period
) (
    input  wire logic                core_clk,              // 25 MHz clock
    input  wire logic                rst_n,                 // Sync reset, active low
    input  wire rafc_pkg::rafc_cfg_t cfg,                   // Configuration
    input  wire logic [VW-1:0]       bus_voltage,           // Bus sample, volts
    input  wire logic [FW-1:0]       ramp_frequency,        // Ramp output, 0.01 Hz
    input  wire logic                accelerating,          // Ramp rising
    input  wire logic                decelerating,          // Ramp falling
    output logic      [FW-1:0]       output_frequency,      // Compensated frequency
    output logic      [FW-1:0]       compensation,          // Added amount
    output logic                     avoidance_active,      // Compensating now
    output logic                     stall_prevention,      // Stall prevention on
    output logic                     ov_stall_for_warning,  // Overvoltage stall to warning
    output logic                     ov_stall_for_timer     // Overvoltage stall to timer
);
    import rafc_pkg::*;

    initial begin
        // Config struct carries 16-bit frequencies; tick counter is 16 bits
        if (VW != 10 || FW != 16 || CYCLE_CLKS < 1 || CYCLE_CLKS > 65536)
            $error("rafc_core: unsupported parameters");
    end

    ////////////////////////////////////////////////////////////////////////
    // Configuration sanitising

    logic [VW-1:0] thr_eff;
    logic [13:0]   lim_eff;
    logic          lim_off;
    logic [7:0]    vgain_eff;
    logic [7:0]    fgain_eff;

    // Out of range settings are clipped rather than rejected
    always_comb begin
        thr_eff = cfg.avoidance_bus_threshold;
        if (thr_eff < `RAFC_THR_MIN) thr_eff = `RAFC_THR_MIN;
        if (thr_eff > `RAFC_THR_MAX) thr_eff = `RAFC_THR_MAX;
        lim_off = (cfg.compensation_freq_limit == `RAFC_LIM_OFF);
        lim_eff = (cfg.compensation_freq_limit > `RAFC_LIM_MAX) ?
                  `RAFC_LIM_MAX : cfg.compensation_freq_limit;
        vgain_eff = (cfg.avoidance_voltage_gain > `RAFC_GAIN_MAX) ?
                    `RAFC_GAIN_MAX : cfg.avoidance_voltage_gain;
        fgain_eff = (cfg.avoidance_frequency_gain > `RAFC_GAIN_MAX) ?
                    `RAFC_GAIN_MAX : cfg.avoidance_frequency_gain;
    end

    ////////////////////////////////////////////////////////////////////////
    // Arming and detection

    logic armed;
    logic over_thr;

    // Below-normal threshold simply keeps this true; no extra guard
    always_comb begin
        over_thr = (bus_voltage >= thr_eff);
        unique case (cfg.avoidance_mode_select)
            `RAFC_MODE_ALWAYS: armed = 1'b1;
            `RAFC_MODE_CONST:  armed = !accelerating && !decelerating;
            default:           armed = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Increment computation

    logic [FW-1:0] excess;
    logic [FW-1:0] excess_v;
    logic [FW-1:0] incr;

    // Excess in volts used directly as 0.01 Hz step at unity gain
    always_comb begin
        excess = over_thr ? FW'(bus_voltage - thr_eff) : '0;
    end

    rafc_scale #(.W(FW)) u_vgain (
        .val  (excess),
        .gain (vgain_eff),
        .res  (excess_v)
    );

    rafc_scale #(.W(FW)) u_fgain (
        .val  (excess_v),
        .gain (fgain_eff),
        .res  (incr)
    );

    ////////////////////////////////////////////////////////////////////////
    // Control cycle tick

    logic [15:0] tick_cnt_q;
    logic [15:0] tick_cnt_d;
    logic        tick;

    // Divider keeps the compensation slope independent of clock rate
    always_comb begin
        tick       = (tick_cnt_q == 16'(CYCLE_CLKS - 1));
        tick_cnt_d = tick ? 16'h0000 : tick_cnt_q + 16'h0001;
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) tick_cnt_q <= 16'h0000;
        else        tick_cnt_q <= tick_cnt_d;
    end

    ////////////////////////////////////////////////////////////////////////
    // Compensation state

    rafc_state_t   st_q, st_d;
    logic [FW-1:0] comp_q, comp_d;
    logic [FW-1:0] base_q, base_d;
    logic [FW:0]   sum;
    logic [FW:0]   cap;
    logic [FW:0]   cap_max;
    logic          at_lim;

    // Cap is limit clamp and maximum clamp, whichever is lower
    always_comb begin
        cap_max = {1'b0, cfg.max_output_frequency};
        cap     = lim_off ? cap_max : ({1'b0, base_q} + {{(FW-13){1'b0}}, lim_eff});
        if (cap > cap_max) cap = cap_max;
        sum     = {1'b0, base_q} + {1'b0, comp_q} + {1'b0, incr};
        at_lim  = !lim_off && (comp_q >= FW'(lim_eff));
    end

    always_comb begin
        st_d   = st_q;
        comp_d = comp_q;
        base_d = base_q;
        unique case (st_q)
            RAFC_IDLE: begin
                base_d = ramp_frequency;
                comp_d = '0;
                if (tick && armed && over_thr) st_d = RAFC_ACT;
            end
            RAFC_ACT: begin
                if (!armed) begin
                    st_d   = RAFC_IDLE;
                    comp_d = '0;
                end else if (tick) begin
                    if (over_thr) begin
                        // Ramp above maximum would make the cap negative
                        if (sum > cap)
                            comp_d = (cap > {1'b0, base_q}) ?
                                     FW'(cap - {1'b0, base_q}) : '0;
                        else
                            comp_d = comp_q + incr;
                    end else if (comp_q != '0) begin
                        comp_d = comp_q - 1'b1;
                    end else begin
                        st_d = RAFC_IDLE;
                    end
                    if (decelerating && at_lim) st_d = RAFC_HOLD;
                    if (!decelerating) base_d = ramp_frequency;
                end
            end
            RAFC_HOLD: begin
                // Limit held until ramp falls to half the limit value
                if (cfg.avoidance_mode_select == `RAFC_MODE_OFF) begin
                    st_d   = RAFC_IDLE;
                    comp_d = '0;
                end else if ({ramp_frequency, 1'b0} <= {2'b00, lim_eff}) begin
                    st_d   = RAFC_ACT;
                    base_d = ramp_frequency;
                end
            end
            default: st_d = RAFC_IDLE;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            st_q   <= RAFC_IDLE;
            comp_q <= '0;
            base_q <= '0;
        end else begin
            st_q   <= st_d;
            comp_q <= comp_d;
            base_q <= base_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs, all registered

    logic [FW:0] out_sum;
    logic [FW-1:0] out_d;
    logic        act_d;

    always_comb begin
        out_sum = {1'b0, ramp_frequency} + {1'b0, comp_d};
        if (out_sum > {1'b0, cfg.max_output_frequency})
            out_d = cfg.max_output_frequency;
        else
            out_d = out_sum[FW-1:0];
        act_d = (st_d != RAFC_IDLE) && (comp_d != '0);
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            output_frequency     <= '0;
            compensation         <= '0;
            avoidance_active     <= 1'b0;
            stall_prevention     <= 1'b0;
            ov_stall_for_warning <= 1'b0;
            ov_stall_for_timer   <= 1'b0;
        end else begin
            output_frequency     <= out_d;
            compensation         <= comp_d;
            avoidance_active     <= act_d;
            stall_prevention     <= act_d;
            ov_stall_for_warning <= act_d;
            ov_stall_for_timer   <= act_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks

    property p_off_no_comp;
        @(posedge core_clk) disable iff (!rst_n)
        (cfg.avoidance_mode_select == `RAFC_MODE_OFF) ##1
        (cfg.avoidance_mode_select == `RAFC_MODE_OFF) |=> compensation == '0;
    endproperty
    a_off_no_comp: assert property (p_off_no_comp)
        else $error("compensation with mode off");

    property p_max_clamp;
        @(posedge core_clk) disable iff (!rst_n)
        1'b1 |=> output_frequency <= $past(cfg.max_output_frequency);
    endproperty
    a_max_clamp: assert property (p_max_clamp)
        else $error("frequency above maximum");

    property p_stall;
        @(posedge core_clk) disable iff (!rst_n)
        stall_prevention == (compensation != '0) && avoidance_active == (compensation != '0);
    endproperty
    a_stall: assert property (p_stall)
        else $error("stall prevention mismatch");

    property p_warn;
        @(posedge core_clk) disable iff (!rst_n)
        ov_stall_for_warning == (compensation != '0)
        && ov_stall_for_timer == (compensation != '0);
    endproperty
    a_warn: assert property (p_warn)
        else $error("overload source mismatch");

    property p_limit;
        @(posedge core_clk) disable iff (!rst_n)
        (!lim_off && st_q == RAFC_ACT) |-> comp_q <= FW'(lim_eff);
    endproperty
    a_limit: assert property (p_limit)
        else $error("compensation above limit");

    property p_detect;
        @(posedge core_clk) disable iff (!rst_n)
        (st_q == RAFC_IDLE && tick && armed && over_thr) |=> st_q == RAFC_ACT;
    endproperty
    a_detect: assert property (p_detect)
        else $error("avoidance not entered");

    property p_const;
        @(posedge core_clk) disable iff (!rst_n)
        (st_q == RAFC_ACT && cfg.avoidance_mode_select == `RAFC_MODE_CONST && accelerating)
        |=> st_q == RAFC_IDLE;
    endproperty
    a_const: assert property (p_const)
        else $error("armed outside constant speed");

    property p_hold;
        @(posedge core_clk) disable iff (!rst_n)
        (st_q == RAFC_HOLD && cfg.avoidance_mode_select != `RAFC_MODE_OFF
         && {ramp_frequency, 1'b0} > {2'b00, lim_eff}) |=> $stable(comp_q);
    endproperty
    a_hold: assert property (p_hold)
        else $error("held compensation changed");

endmodule : rafc_core

// ---- rafc_stage_model.sv ----
// Purpose: behavioural power stage that feeds the compensator its bus and ramp
// Assumes: the bench commands the bus level, the ramp frequency and the direction
// Notes:   outputs are registered, so the sensed values lag the commands by one clock
`timescale 1ns/100ps
module rafc_stage_model (
    input  wire logic        core_clk,        // System clock
    input  wire logic [9:0]  bus_cmd,         // Commanded bus volts
    input  wire logic [15:0] ramp_cmd,        // Commanded ramp frequency
    input  wire logic [1:0]  dir_cmd,         // Bit 1 accel, bit 0 decel
    output logic      [9:0]  bus_voltage,     // Sensed bus volts
    output logic      [15:0] ramp_frequency,  // Ramp output frequency
    output logic             accelerating,    // Ramp rising
    output logic             decelerating     // Ramp falling
);
    ////////////////////////////////////////////////////////////////////////////
    // Known levels from time zero, so the block never sees an unknown sample
    initial begin
        bus_voltage    = 10'h000;
        ramp_frequency = 16'h0000;
        accelerating   = 1'b0;
        decelerating   = 1'b0;
    end

    // Sampled sensing path, like a converter with one clock of latency
    always @(posedge core_clk) begin
        bus_voltage    <= bus_cmd;
        ramp_frequency <= ramp_cmd;
        accelerating   <= dir_cmd[1];
        decelerating   <= dir_cmd[0];
    end
endmodule : rafc_stage_model

// ---- regen_avoidance_freq_comp_bench.sv ----
// Purpose: self-checking bench for the regeneration avoidance compensator
// Assumes: control period shortened to 4 clocks, frequencies in 0.01 Hz
// Notes:   each start call gives a fresh reset with its own settings; the bus-drop and acceleration scenarios carry on without one
`timescale 1ns/100ps
`include "rafc_defines.svh"
module regen_avoidance_freq_comp_bench;
    import rafc_pkg::*;
    localparam int CYC = 4;

    logic        core_clk = 1'b0;
    logic        rst_n    = 1'b0;
    rafc_cfg_t   cfg;
    logic [9:0]  bus_cmd;
    logic [15:0] ramp_cmd;
    logic [1:0]  dir_cmd;
    logic [9:0]  bus_voltage;
    logic [15:0] ramp_frequency;
    logic        accelerating;
    logic        decelerating;
    logic [15:0] output_frequency;
    logic [15:0] compensation;
    logic        avoidance_active;
    logic        stall_prevention;
    logic        ov_stall_for_warning;
    logic        ov_stall_for_timer;
    int          fail_count  = 0;
    int          check_count = 0;

    ////////////////////////////////////////////////////////////////////////////
    // 25 MHz clock
    always #20 core_clk = ~core_clk;

    rafc_stage_model stage (.core_clk(core_clk), .bus_cmd(bus_cmd), .ramp_cmd(ramp_cmd),
        .dir_cmd(dir_cmd), .bus_voltage(bus_voltage), .ramp_frequency(ramp_frequency),
        .accelerating(accelerating), .decelerating(decelerating));

    rafc_core #(.CYCLE_CLKS(CYC)) dut (.core_clk(core_clk), .rst_n(rst_n), .cfg(cfg),
        .bus_voltage(bus_voltage), .ramp_frequency(ramp_frequency),
        .accelerating(accelerating), .decelerating(decelerating),
        .output_frequency(output_frequency), .compensation(compensation),
        .avoidance_active(avoidance_active), .stall_prevention(stall_prevention),
        .ov_stall_for_warning(ov_stall_for_warning), .ov_stall_for_timer(ov_stall_for_timer));

    ////////////////////////////////////////////////////////////////////////////
    // Verdict and end of run, shared by the main sequence and the wait limit
    task automatic end_of_test();
        if (fail_count == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // Inputs always move 1 ns after the edge, never on it
    task automatic run(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : run

    // Fresh reset for 4 clocks with the scenario's settings already applied
    task automatic start(input logic [1:0] md, input logic [9:0] thr, input logic [13:0] lim,
                         input logic [7:0] vg, input logic [7:0] fg, input logic [15:0] mx,
                         input logic [9:0] bus, input logic [15:0] ramp, input logic [1:0] dir);
        rst_n    = 1'b0;
        cfg      = '{md, thr, lim, vg, fg, mx};
        bus_cmd  = bus;
        ramp_cmd = ramp;
        dir_cmd  = dir;
        run(4);
        rst_n = 1'b1;
    endtask : start

    // Bounded wait: for idle, or for compensation to leave a value
    task automatic wait_for(input bit idle, input logic [15:0] old);
        int i;
        for (i = 0; i < 4000; i++) begin
            run(1);
            if (idle ? (avoidance_active === 1'b0) : (compensation !== old)) break;
        end
        if (i == 4000) begin
            fail_count++;
            $display("MISMATCH %0t wait ran out", $time);
            end_of_test();
        end
    endtask : wait_for

    ////////////////////////////////////////////////////////////////////////////
    // Scenarios; steps of 100 come from 100 V excess at unity gains
    initial begin
        // Mode off with the bus far above threshold
        start(`RAFC_MODE_OFF, 10'h190, 14'h0258, 8'h64, 8'h64, 16'h1388, 10'h1F4, 16'h03E8, 2'b00);
        run(60);
        chk(compensation, 16'h0000);
        chk({15'h0000, avoidance_active}, 16'h0000);
        chk(output_frequency, 16'h03E8);
        // Constant-speed mode refuses while accelerating, acts once steady
        start(`RAFC_MODE_CONST, 10'h190, 14'h0258, 8'h64, 8'h64, 16'h1388, 10'h1F4, 16'h03E8,
              2'b10);
        run(60);
        chk(compensation, 16'h0000);
        dir_cmd = 2'b00;
        wait_for(1'b0, 16'h0000);
        chk(compensation, 16'h0064);
        chk({12'h000, avoidance_active, stall_prevention, ov_stall_for_warning,
             ov_stall_for_timer}, 16'h000F);
        chk(output_frequency, 16'h044C);
        run(100);
        chk(compensation, 16'h0258);
        chk(output_frequency, 16'h0640);
        // Bus drops below threshold: decay back to idle, flags fall together
        bus_cmd = 10'h186;
        wait_for(1'b1, 16'h0000);
        chk(compensation, 16'h0000);
        chk({12'h000, avoidance_active, stall_prevention, ov_stall_for_warning,
             ov_stall_for_timer}, 16'h0000);
        // Acceleration in constant-speed mode drops compensation at once
        bus_cmd = 10'h1F4;
        wait_for(1'b0, 16'h0000);
        dir_cmd = 2'b10;
        run(4);
        chk(compensation, 16'h0000);
        chk(output_frequency, 16'h03E8);
        dir_cmd = 2'b00;
        // Halved voltage and frequency gains give a quarter of the step
        start(`RAFC_MODE_ALWAYS, 10'h190, 14'h0258, 8'h32, 8'h32, 16'h1388, 10'h1F4, 16'h03E8,
              2'b00);
        wait_for(1'b0, 16'h0000);
        chk(compensation, 16'h0019);
        // Limit off: only the maximum frequency bounds the rise
        start(`RAFC_MODE_ALWAYS, 10'h190, 14'h270F, 8'h64, 8'h64, 16'h042E, 10'h1AE, 16'h03E8,
              2'b00);
        run(100);
        chk(compensation, 16'h0046);
        chk(output_frequency, 16'h042E);
        // Threshold below the minimum clips to 300 V; voltage gain clips to 200
        start(`RAFC_MODE_ALWAYS, 10'h064, 14'h0258, 8'hFF, 8'h64, 16'h1388, 10'h136, 16'h01F4,
              2'b00);
        wait_for(1'b0, 16'h0000);
        chk(compensation, 16'h0014);
        // Oversized limit clips to 10 Hz
        start(`RAFC_MODE_ALWAYS, 10'h12C, 14'h07D0, 8'hC8, 8'hC8, 16'hFFFF, 10'h320, 16'h03E8,
              2'b00);
        run(60);
        chk(compensation, 16'h03E8);
        chk(output_frequency, 16'h07D0);
        // Deceleration: limit is held until the ramp reaches half the limit
        start(`RAFC_MODE_ALWAYS, 10'h190, 14'h0064, 8'h64, 8'h64, 16'h1388, 10'h1F4, 16'h03E8,
              2'b01);
        run(40);
        chk(compensation, 16'h0064);
        bus_cmd = 10'h186;
        run(40);
        chk(compensation, 16'h0064);
        ramp_cmd = 16'h0032;
        wait_for(1'b0, 16'h0064);
        chk(compensation, 16'h0063);
        end_of_test();
    end
endmodule : regen_avoidance_freq_comp_bench
